// file: dv/tb.sv
// Self-checking bench for the status, event and mask bank
`timescale 1ns/1ps

module tb;
	logic CLOCK;
	logic RST;
	logic [10:0] pins; // cc1 cc2 fault vbus level[1:0] att sink src dbg aud
	logic acc_present;
	logic gmask;
	logic scl;
	logic sda_low;
	logic sda;
	logic sda_oe;
	logic sda_out;
	logic int_n;
	logic soft_out;
	int soft_pulses = 0;
	logic [7:0] rd;
	int mismatches;
	int compares;
	logic [26:0] rows [4];

	// Open-drain data line with pull-up; a released line reads high
	assign sda = ~sda_low & (sda_oe ? sda_out : 1'b1);

	// Counts soft reset pulses, which are too short to poll for
	always @(posedge CLOCK) begin
		if (soft_out === 1'b1)
			soft_pulses <= soft_pulses + 1;
	end

	// 200 MHz clock
	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end

	tcser_regs i_tcser_regs (.CLOCK(CLOCK), .RST(RST), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.CC1_DETECTED(pins[10]),
		.CC2_DETECTED(pins[9]), .DETECT_FAULT(pins[8]),
		.BUS_VOLTAGE_VALID(pins[7]), .ADVERTISED_CURRENT_LEVEL(pins[6:5]),
		.PORT_ATTACHED(pins[4]), .SINK_FOUND(pins[3]),
		.SOURCE_FOUND(pins[2]), .DEBUG_ACCESSORY_FOUND(pins[1]),
		.AUDIO_ACCESSORY_FOUND(pins[0]), .ACCESSORY_PRESENT(acc_present),
		.GLOBAL_EVENT_MASK(gmask), .INT_N(int_n), .SOFT_RESET_OUT(soft_out));

	tcser_host i_tcser_host (.clk(CLOCK), .sda(sda), .scl(scl),
		.sda_low(sda_low));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a,
		input logic [7:0] exp);
		i_tcser_host.read_reg(a, rd);
		check(name, rd, exp);
	endtask

	// Status inputs change at a clock edge, then settle past the latency
	task automatic poke(input logic [10:0] p, input logic acc);
		@(posedge CLOCK);
		pins <= p;
		acc_present <= acc;
		repeat (8) @(posedge CLOCK);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		RST = 1'b1;
		pins = 11'h000;
		acc_present = 1'b0;
		gmask = 1'b0;
		mismatches = 0;
		compares = 0;
		// Pins, then status and type images, one row per detection case
		rows = '{{11'h4B8, 8'h1B, 8'h10}, {11'h254, 8'h25, 8'h08},
			{11'h1E2, 8'h3E, 8'h02}, {11'h011, 8'h01, 8'h01}};
		repeat (2) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (4) @(posedge CLOCK);
		check("int after reset", {7'h00, int_n}, 8'h01);
		foreach (rows[i]) begin
			poke(rows[i][26:16], 1'b0);
			rd_chk("status", 8'h11, rows[i][15:8]);
			rd_chk("type", 8'h12, rows[i][7:0]);
		end
		i_tcser_host.write_reg(8'h10, 8'h0F);
		rd_chk("mask", 8'h10, 8'h0F);
		i_tcser_host.write_reg(8'h13, 8'h0F);
		rd_chk("flags cleared", 8'h13, 8'h00);
		check("int cleared", {7'h00, int_n}, 8'h01);
		// Every event under a full mask: accessory, detach, attach, level
		poke(11'h023, 1'b1);
		poke(11'h023, 1'b0);
		poke(11'h003, 1'b0);
		poke(11'h033, 1'b0);
		poke(11'h043, 1'b0);
		rd_chk("flags all", 8'h13, 8'h0F);
		check("int masked", {7'h00, int_n}, 8'h01);
		for (int b = 0; b < 4; b++) begin
			i_tcser_host.write_reg(8'h10, 8'h0F ^ (8'h01 << b));
			check("int unmasked", {7'h00, int_n}, 8'h00);
		end
		@(posedge CLOCK);
		gmask <= 1'b1;
		repeat (4) @(posedge CLOCK);
		check("int global", {7'h00, int_n}, 8'h01);
		gmask <= 1'b0;
		repeat (4) @(posedge CLOCK);
		check("int global off", {7'h00, int_n}, 8'h00);
		// Clearing the only unmasked flag releases the interrupt
		i_tcser_host.write_reg(8'h13, 8'h08);
		check("int after clear", {7'h00, int_n}, 8'h01);
		rd_chk("flags w1c", 8'h13, 8'h07);
		rd_chk("unmapped", 8'h20, 8'h00);
		rd_chk("reset reg", 8'h05, 8'h00);
		i_tcser_host.write_reg(8'h05, 8'h01);
		check("soft pulses", soft_pulses[7:0], 8'h01);
		rd_chk("mask after soft", 8'h10, 8'h00);
		// Status restarts from zero, so the held level code counts as a change
		rd_chk("flags after soft", 8'h13, 8'h04);
		check("int after soft", {7'h00, int_n}, 8'h00);
		// Asynchronous reset in mid-run
		i_tcser_host.write_reg(8'h10, 8'h05);
		@(posedge CLOCK);
		RST <= 1'b1;
		repeat (2) @(posedge CLOCK);
		check("int in reset", {7'h00, int_n}, 8'h01);
		RST <= 1'b0;
		repeat (4) @(posedge CLOCK);
		rd_chk("mask after reset", 8'h10, 8'h00);
		print_verdict();
	end

	// Watchdog against a hung run
	initial begin
		repeat (100000) @(posedge CLOCK);
		mismatches++;
		print_verdict();
	end
endmodule // tb

// file: dv/tcser_host.sv
// Host processor model driving the serial register link
`timescale 1ns/1ps

module tcser_host #(
	parameter logic [6:0] ADDR = 7'h25, // Arbitrary device address
	parameter int HALF = 12 // Clocks per serial clock half period
) (
	input wire logic clk, // System clock
	input wire logic sda, // Resolved data line
	output logic scl, // Serial clock
	output logic sda_low // Pull data line low
);
	// Idle lines high until the first transfer
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ----------------------------------------------------------------
	// Line steps; data moves two clocks after the clock falls, so the
	// device filter never sees both lines change together
	// ----------------------------------------------------------------
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic put_bit(input logic b);
		hold(2);
		sda_low <= ~b;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF);
		scl <= 1'b0;
	endtask

	task automatic get_bit(output logic b);
		hold(2);
		sda_low <= 1'b0;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF / 2);
		b = sda;
		hold(HALF / 2);
		scl <= 1'b0;
	endtask

	task automatic start();
		hold(2);
		sda_low <= 1'b0;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF);
		sda_low <= 1'b1;
		hold(HALF);
		scl <= 1'b0;
	endtask

	task automatic stop();
		hold(2);
		sda_low <= 1'b1;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF);
		sda_low <= 1'b0;
		hold(HALF);
	endtask

	// Byte out, most significant bit first, acknowledge slot ignored
	task automatic send(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(a);
	endtask

	// ----------------------------------------------------------------
	// Register accesses
	// ----------------------------------------------------------------
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		start();
		send({ADDR, 1'b0});
		send(a);
		send(d);
		stop();
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		start();
		send({ADDR, 1'b0});
		send(a);
		start();
		send({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(1'b1); // Not-acknowledge ends the read
		stop();
	endtask
endmodule // tcser_host

// file: dv/tcser_regs_assertions.sv
// Port assertions for the status, event and mask bank
`timescale 1ns/1ps

module tcser_regs_assertions (
	input wire logic CLOCK, // System clock
	input wire logic RST, // Async reset
	input wire logic SCL_IN, // Serial clock pin
	input wire logic SDA_OUT, // Data drive value
	input wire logic SDA_OE, // Data pull-down enable
	input wire logic [1:0] ADVERTISED_CURRENT_LEVEL, // Level code
	input wire logic PORT_ATTACHED, // Partner connected
	input wire logic ACCESSORY_PRESENT, // Accessory present state
	input wire logic GLOBAL_EVENT_MASK, // Global mask
	input wire logic INT_N, // Interrupt, active low
	input wire logic SOFT_RESET_OUT // Soft reset pulse
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	// ----------------------------------------------------------------
	// Event history
	// ----------------------------------------------------------------
	logic att_q;
	logic acc_q;
	logic gm_q;
	logic [1:0] lvl_q;
	logic [7:0] ev_hist;
	logic ev_now;

	// Anything that may set or unmask a flag; kept eight cycles so the
	// interrupt latency can be checked without seeing the mask register
	assign ev_now = (PORT_ATTACHED != att_q) |
		(ADVERTISED_CURRENT_LEVEL != lvl_q) | (acc_q & ~ACCESSORY_PRESENT) |
		(gm_q & ~GLOBAL_EVENT_MASK) | SOFT_RESET_OUT;

	// Previous input levels and the history shift
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			att_q <= 1'b0;
			acc_q <= 1'b0;
			gm_q <= 1'b0;
			lvl_q <= 2'h0;
			ev_hist <= 8'h00;
		end else begin
			att_q <= PORT_ATTACHED;
			acc_q <= ACCESSORY_PRESENT;
			gm_q <= GLOBAL_EVENT_MASK;
			lvl_q <= ADVERTISED_CURRENT_LEVEL;
			ev_hist <= {ev_hist[6:0], ev_now};
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_gmask_held;
		GLOBAL_EVENT_MASK [*2];
	endsequence

	sequence s_int_released;
		##[1:3] INT_N;
	endsequence

	gmask_blocks_a: assert property (s_gmask_held |=> INT_N)
		else $error("interrupt active under global mask");
	int_fall_cause_a: assert property (
		$fell(INT_N) && SCL_IN |-> |ev_hist)
		else $error("interrupt fell with no event behind it");
	int_rise_cause_a: assert property ($rose(INT_N) |->
		!SCL_IN || $past(GLOBAL_EVENT_MASK))
		else $error("interrupt released with no write or mask");
	soft_pulse_one_a: assert property (
		SOFT_RESET_OUT |=> !SOFT_RESET_OUT)
		else $error("soft reset pulse longer than one cycle");
	soft_in_write_a: assert property (SOFT_RESET_OUT |-> !SCL_IN)
		else $error("soft reset outside a write acknowledge");
	soft_clears_int_a: assert property (
		SOFT_RESET_OUT |-> s_int_released)
		else $error("interrupt not released by soft reset");
	sda_drive_low_a: assert property (!SDA_OUT)
		else $error("data line driven high");
	sda_steady_a: assert property ($changed(SDA_OE) |-> !SCL_IN)
		else $error("data line moved while serial clock high");
endmodule // tcser_regs_assertions

bind tcser_regs tcser_regs_assertions i_tcser_regs_assertions (
	.CLOCK(CLOCK), .RST(RST), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
	.SDA_OE(SDA_OE), .ADVERTISED_CURRENT_LEVEL(ADVERTISED_CURRENT_LEVEL),
	.PORT_ATTACHED(PORT_ATTACHED), .ACCESSORY_PRESENT(ACCESSORY_PRESENT),
	.GLOBAL_EVENT_MASK(GLOBAL_EVENT_MASK), .INT_N(INT_N),
	.SOFT_RESET_OUT(SOFT_RESET_OUT));

// file: logic/tcser_regs.sv
// Serially reached status, event and mask register bank of a port controller
`timescale 1ns/1ps
`include "tcser_defines.svh"

// Contract
// RULE1 - Writing one to soft reset bit resets the whole bank and controller.
// RULE2 - Accessory change mask one keeps accessory change off the interrupt.
// RULE3 - Current level mask one keeps level change event off the interrupt.
// RULE4 - Detach mask one keeps the removal event off the interrupt.
// RULE5 - Attach mask one keeps the connection event off the interrupt.
// RULE6 - Orientation reads 01 CC1, 10 CC2, 11 fault, 00 otherwise.
// RULE7 - Bus voltage valid bit follows sensed VBUS range.
// RULE8 - Current level field encodes 00 Ra, 01 default, 10 1.5A, 11 3A.
// RULE9 - Attached bit is one while a partner is connected.
// RULE10 - Type bit 4 flags a sink, bit 3 a source.
// RULE11 - Type bit 1 flags debug accessory, bit 0 audio accessory.
// RULE12 - Accessory change flag sets on accessory present to audio or debug.
// RULE13 - Current level flag sets whenever the level field changes.
// RULE14 - Removal flag sets when an attached partner detaches.
// RULE15 - Connection flag sets when a partner becomes attached.
// RULE16 - Global mask one stops every event from raising the interrupt.
// RULE17 - Flags clear by writing one; soft reset bit clears itself.
// RULE18 - Interrupt asserts while an unmasked flag is set and no global mask.
module tcser_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h25 // Arbitrary default address
) (
	input wire logic CLOCK, // System clock, 200 MHz
	input wire logic RST, // Asynchronous reset, active high
	input wire logic SCL_IN, // Serial clock pin level
	input wire logic SDA_IN, // Serial data pin level
	output logic SDA_OUT, // Serial data drive value, always low
	output logic SDA_OE, // Serial data pull-down enable
	input wire logic CC1_DETECTED, // Cable CC found on first pin
	input wire logic CC2_DETECTED, // Cable CC found on second pin
	input wire logic DETECT_FAULT, // Detection fault seen
	input wire logic BUS_VOLTAGE_VALID, // VBUS within valid range
	input wire logic [1:0] ADVERTISED_CURRENT_LEVEL, // Current threshold code
	input wire logic PORT_ATTACHED, // Partner connected
	input wire logic SINK_FOUND, // Sink partner detected
	input wire logic SOURCE_FOUND, // Source partner detected
	input wire logic DEBUG_ACCESSORY_FOUND, // Debug accessory detected
	input wire logic AUDIO_ACCESSORY_FOUND, // Audio accessory detected
	input wire logic ACCESSORY_PRESENT, // Controller in accessory present
	input wire logic GLOBAL_EVENT_MASK, // Global interrupt mask
	output logic INT_N, // Interrupt, active low
	output logic SOFT_RESET_OUT // One-cycle reset to the controller
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [1:0] line;
	logic scl, sda, scl_prev, sda_prev;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	tcser_pkg::tcser_state_t state;
	logic [3:0] bitcnt;
	logic [7:0] shift, ptr, wr_addr, wr_data, rd_data;
	logic read_mode, master_nack, wr_stb;
	logic [3:0] mask, flags, next_set, clr;
	logic [7:0] port_status, partner_kind, prev_status;
	logic acc_present, prev_acc_present;
	logic [1:0] orient;

	// ----------------------------------------------------------------
	// Pin synchronisers and line conditions
	// ----------------------------------------------------------------
	tcser_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(CLOCK),
		.rst(RST),
		.din({SCL_IN, SDA_IN}),
		.dout(line)
	);

	assign scl = line[1];
	assign sda = line[0];

	// Previous filtered levels for edge detection
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			scl_prev <= `TCSER_LINE_IDLE;
			sda_prev <= `TCSER_LINE_IDLE;
		end else begin
			scl_prev <= scl;
			sda_prev <= sda;
		end
	end

	assign scl_rise = scl & ~scl_prev;
	assign scl_fall = ~scl & scl_prev;
	assign start_cond = scl & scl_prev & sda_prev & ~sda;
	assign stop_cond = scl & scl_prev & ~sda_prev & sda;

	// ----------------------------------------------------------------
	// Serial slave sequence
	// ----------------------------------------------------------------
	// Data moves on SCL falls and is sampled on rises, so the master
	// always sees a settled line while the clock is high
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state <= tcser_pkg::ST_IDLE;
			bitcnt <= `TCSER_BITCNT_RESET;
			shift <= `TCSER_BYTE_RESET;
			ptr <= `TCSER_BYTE_RESET;
			read_mode <= 1'b0;
			master_nack <= 1'b0;
			SDA_OE <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= `TCSER_BYTE_RESET;
			wr_data <= `TCSER_BYTE_RESET;
			SDA_OUT <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			SDA_OUT <= 1'b0; // Open drain: the pin only ever pulls low
			if (start_cond) begin
				state <= tcser_pkg::ST_ADDR;
				bitcnt <= `TCSER_BITCNT_RESET;
				SDA_OE <= 1'b0;
			end else if (stop_cond) begin
				state <= tcser_pkg::ST_IDLE;
				SDA_OE <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					tcser_pkg::ST_ADDR,
					tcser_pkg::ST_REG,
					tcser_pkg::ST_WDATA: begin
						shift <= {shift[6:0], sda};
						bitcnt <= bitcnt + `TCSER_BITCNT_STEP;
					end
					tcser_pkg::ST_RDATA: begin
						bitcnt <= bitcnt + `TCSER_BITCNT_STEP;
					end
					tcser_pkg::ST_MACK: begin
						master_nack <= sda;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					tcser_pkg::ST_ADDR: begin
						if (bitcnt == `TCSER_BITS_PER_BYTE) begin
							// Only our own address is acknowledged
							if (shift[7:1] == DEV_ADDR) begin
								state <= tcser_pkg::ST_ACK_ADDR;
								read_mode <= shift[0];
								SDA_OE <= 1'b1;
							end else begin
								state <= tcser_pkg::ST_IDLE;
							end
						end
					end
					tcser_pkg::ST_ACK_ADDR: begin
						bitcnt <= `TCSER_BITCNT_RESET;
						if (read_mode) begin
							state <= tcser_pkg::ST_RDATA;
							shift <= rd_data;
							SDA_OE <= ~rd_data[7];
						end else begin
							state <= tcser_pkg::ST_REG;
							SDA_OE <= 1'b0;
						end
					end
					tcser_pkg::ST_REG: begin
						if (bitcnt == `TCSER_BITS_PER_BYTE) begin
							state <= tcser_pkg::ST_ACK_REG;
							ptr <= shift;
							SDA_OE <= 1'b1;
						end
					end
					tcser_pkg::ST_WDATA: begin
						if (bitcnt == `TCSER_BITS_PER_BYTE) begin
							state <= tcser_pkg::ST_ACK_DATA;
							wr_stb <= 1'b1;
							wr_addr <= ptr;
							wr_data <= shift;
							ptr <= ptr + 8'h01;
							SDA_OE <= 1'b1;
						end
					end
					tcser_pkg::ST_ACK_REG,
					tcser_pkg::ST_ACK_DATA: begin
						state <= tcser_pkg::ST_WDATA;
						bitcnt <= `TCSER_BITCNT_RESET;
						SDA_OE <= 1'b0;
					end
					tcser_pkg::ST_RDATA: begin
						if (bitcnt == `TCSER_BITS_PER_BYTE) begin
							state <= tcser_pkg::ST_MACK;
							ptr <= ptr + 8'h01;
							SDA_OE <= 1'b0;
						end else begin
							shift <= {shift[6:0], 1'b0};
							SDA_OE <= ~shift[6];
						end
					end
					tcser_pkg::ST_MACK: begin
						// A master NACK ends the burst until STOP or START
						if (master_nack) begin
							state <= tcser_pkg::ST_IDLE;
						end else begin
							state <= tcser_pkg::ST_RDATA;
							bitcnt <= `TCSER_BITCNT_RESET;
							shift <= rd_data;
							SDA_OE <= ~rd_data[7];
						end
					end
					default: begin
						SDA_OE <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	// Soft reset bit always reads zero since it clears itself
	always_comb begin
		case (ptr)
			`TCSER_ADDR_RESET: rd_data = `TCSER_BYTE_RESET; // RULE17
			`TCSER_ADDR_MASK: rd_data = {`TCSER_UNUSED_BITS, mask};
			`TCSER_ADDR_STATUS: rd_data = port_status;
			`TCSER_ADDR_TYPE: rd_data = partner_kind;
			`TCSER_ADDR_EVENT: rd_data = {`TCSER_UNUSED_BITS, flags};
			default: rd_data = `TCSER_BYTE_RESET;
		endcase
	end

	// ----------------------------------------------------------------
	// Soft reset command
	// ----------------------------------------------------------------
	// Pulses one cycle after the write, then drops by itself
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			SOFT_RESET_OUT <= 1'b0;
		end else begin
			SOFT_RESET_OUT <= wr_stb & (wr_addr == `TCSER_ADDR_RESET) &
				wr_data[`TCSER_BIT_SOFT_RESET]; // RULE1 RULE17
		end
	end

	// ----------------------------------------------------------------
	// Mask register
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			mask <= `TCSER_MASK_RESET;
		end else if (SOFT_RESET_OUT) begin
			mask <= `TCSER_MASK_RESET; // RULE1
		end else if (wr_stb && wr_addr == `TCSER_ADDR_MASK) begin
			mask <= wr_data[3:0];
		end
	end

	// ----------------------------------------------------------------
	// Status and partner kind capture
	// ----------------------------------------------------------------
	// Fault outranks either pin so a confused detector never looks clean
	always_comb begin
		if (DETECT_FAULT || (CC1_DETECTED && CC2_DETECTED)) begin
			orient = `TCSER_ORIENT_FAULT; // RULE6
		end else if (CC1_DETECTED) begin
			orient = `TCSER_ORIENT_CC1; // RULE6
		end else if (CC2_DETECTED) begin
			orient = `TCSER_ORIENT_CC2; // RULE6
		end else begin
			orient = `TCSER_ORIENT_NONE; // RULE6
		end
	end

	// Inputs come from logic on this clock, so no synchroniser
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			port_status <= `TCSER_BYTE_RESET;
			partner_kind <= `TCSER_BYTE_RESET;
			prev_status <= `TCSER_BYTE_RESET;
			acc_present <= 1'b0;
			prev_acc_present <= 1'b0;
		end else if (SOFT_RESET_OUT) begin
			port_status <= `TCSER_BYTE_RESET; // RULE1
			partner_kind <= `TCSER_BYTE_RESET;
			prev_status <= `TCSER_BYTE_RESET;
			acc_present <= 1'b0;
			prev_acc_present <= 1'b0;
		end else begin
			port_status <= {2'b00, orient, BUS_VOLTAGE_VALID, // RULE7
				ADVERTISED_CURRENT_LEVEL, PORT_ATTACHED}; // RULE8 RULE9
			partner_kind <= {3'b000, SINK_FOUND, SOURCE_FOUND, // RULE10
				1'b0, DEBUG_ACCESSORY_FOUND, AUDIO_ACCESSORY_FOUND}; // RULE11
			prev_status <= port_status;
			acc_present <= ACCESSORY_PRESENT;
			prev_acc_present <= acc_present;
		end
	end

	// ----------------------------------------------------------------
	// Event detection and flags
	// ----------------------------------------------------------------
	// Edges are taken between the captured copy and the one before
	always_comb begin
		next_set[`TCSER_EV_ATTACH] = port_status[0] & ~prev_status[0]; // RULE15
		next_set[`TCSER_EV_DETACH] = ~port_status[0] & prev_status[0]; // RULE14
		next_set[`TCSER_EV_LEVEL] =
			port_status[2:1] != prev_status[2:1]; // RULE13
		next_set[`TCSER_EV_ACC] = prev_acc_present & ~acc_present &
			(partner_kind[1] | partner_kind[0]); // RULE12
	end

	assign clr = (wr_stb && wr_addr == `TCSER_ADDR_EVENT) ?
		wr_data[3:0] : `TCSER_FLAGS_RESET;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			flags <= `TCSER_FLAGS_RESET;
		end else if (SOFT_RESET_OUT) begin
			flags <= `TCSER_FLAGS_RESET; // RULE1
		end else begin
			flags <= (flags & ~clr) | next_set; // RULE17
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	// Per-bit masks hide only the notice; the flag itself still sets
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			INT_N <= 1'b1;
		end else begin
			INT_N <= ~((|(flags & ~mask)) & // RULE2 RULE3 RULE4 RULE5
				~GLOBAL_EVENT_MASK); // RULE16 RULE18
		end
	end

endmodule // tcser_regs

// file: logic/tcser_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`include "tcser_defines.svh"

module tcser_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [WIDTH-1:0] din, // Asynchronous pin levels
	output logic [WIDTH-1:0] dout // Filtered level
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// ----------------------------------------------------------------
	// Per-bit chain
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// Lines idle high, so reset to one avoids a false start
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					stage1[i] <= `TCSER_LINE_IDLE;
					stage2[i] <= `TCSER_LINE_IDLE;
					stage3[i] <= `TCSER_LINE_IDLE;
					dout[i] <= `TCSER_LINE_IDLE;
				end else begin
					stage1[i] <= din[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
					// A change counts only once two late stages agree
					if (stage2[i] == stage3[i]) begin
						dout[i] <= stage3[i];
					end
				end
			end
		end
	endgenerate

endmodule // tcser_sync

// file: pkg/tcser_defines.svh
// Register offsets, field positions and reset values of the status bank
`ifndef TCSER_DEFINES_SVH
`define TCSER_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TCSER_ADDR_RESET 8'h05
`define TCSER_ADDR_MASK 8'h10
`define TCSER_ADDR_STATUS 8'h11
`define TCSER_ADDR_TYPE 8'h12
`define TCSER_ADDR_EVENT 8'h13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCSER_BIT_SOFT_RESET 0
`define TCSER_EV_ATTACH 0
`define TCSER_EV_DETACH 1
`define TCSER_EV_LEVEL 2
`define TCSER_EV_ACC 3
`define TCSER_ORIENT_CC1 2'h1
`define TCSER_ORIENT_CC2 2'h2
`define TCSER_ORIENT_FAULT 2'h3
`define TCSER_ORIENT_NONE 2'h0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define TCSER_MASK_RESET 4'h0
`define TCSER_FLAGS_RESET 4'h0
`define TCSER_BYTE_RESET 8'h00
`define TCSER_UNUSED_BITS 4'h0
`define TCSER_BITS_PER_BYTE 4'h8
`define TCSER_BITCNT_RESET 4'h0
`define TCSER_BITCNT_STEP 4'h1
`define TCSER_LINE_IDLE 1'b1

`endif

// file: pkg/tcser_pkg.sv
// Types shared by the status bank design files
package tcser_pkg;

	// Serial slave sequence states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_REG,
		ST_ACK_REG,
		ST_WDATA,
		ST_ACK_DATA,
		ST_RDATA,
		ST_MACK
	} tcser_state_t;

endpackage
